// *** verilog/signed_adder_datapath.sv ***
// Sixteen-bit two's complement adder datapath with complementing bus
// gates, an operand holding register and a built-in subtract sequence.
// Assumes a control sequencer drives the strobes synchronously to
// sys_clk_i and presents memory data in the cycle of its load strobe.
`timescale 1ns/1ps
`default_nettype none
`include "adder_params.svh"

// Function
// - Data words are sixteen-bit two's complement values.
// - Bit fifteen is the sign.
// - Sign zero is positive, magnitude in bits 0-14.
// - Largest positive value is 0x7fff.
// - Sign one negative; value plus negation gives zero.
// - Negate by inverting, then adding one via carry.
// - No subtractor; adding negation gives the difference.
// - Invert A/X onto S, R onto U.
// - Adder sums S bus, U bus and carry-in.
// - Subtract loads operand register before adder gating.
// - Subtract gates inverted operand with carry one.
// - Subtract adds plain accumulator, writes accumulator back.
// - Adder output passes unchanged to result, strobed in; here result is clocked in every cycle.
module signed_adder_datapath
  import adder_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // Operand from memory
  input  wire adder_pkg::word_t  mem_data_i,
  input  wire logic              load_r_i,
  // Bus gating strobes
  input  wire logic              gate_a_s_i,
  input  wire logic              gate_x_s_i,
  input  wire logic              inv_s_i,
  input  wire logic              gate_r_u_i,
  input  wire logic              inv_u_i,
  input  wire logic              carry_in_i,
  // Store strobes
  input  wire logic              store_a_i,
  input  wire logic              store_x_i,
  // Subtract-from-memory sequence
  input  wire logic              sub_start_i,
  output logic                   busy_o,
  output logic                   done_o,
  // Register contents
  output adder_pkg::word_t       acc_o,
  output adder_pkg::word_t       idx_o,
  output adder_pkg::word_t       opnd_o,
  // Result bus and status of the last sum
  output adder_pkg::word_t       result_o,
  output logic                   sign_o,
  output logic                   zero_o,
  output logic                   carry_o,
  output logic                   ovf_o
);

  import adder_pkg::*;

  // ==========================================================
  // Storage
  // ==========================================================
  word_t      acc_q;
  word_t      idx_q;
  word_t      opnd_q;
  word_t      result_q;
  logic       sign_q;
  logic       zero_q;
  logic       carry_q;
  logic       ovf_q;
  seq_state_t state_q;
  seq_state_t state_d;

  // Effective controls after the sequencer has had its say.
  logic       idle;
  logic       exec;
  logic       g_a;
  logic       g_x;
  logic       i_s;
  logic       g_r;
  logic       i_u;
  logic       cin;
  logic       st_a;
  logic       st_x;
  logic       ld_r;

  word_t      s_bus;
  word_t      u_bus;
  word_t      sum;
  logic       sum_carry;
  logic       sum_ovf;

  // ==========================================================
  // Subtract sequence
  // ==========================================================
  assign idle = (state_q == SEQ_IDLE);
  assign exec = (state_q == SEQ_EXEC);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE:
      begin
        if (sub_start_i)
        begin
          state_d = SEQ_EXEC;
        end
      end
      SEQ_EXEC:
      begin
        state_d = SEQ_DONE;
      end
      SEQ_DONE:
      begin
        state_d = SEQ_IDLE;
      end
      default:
      begin
        state_d = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= SEQ_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // While the sequence runs, the external strobes are ignored so that
  // the sequencer cannot corrupt a subtract half way through.
  assign ld_r = idle & (load_r_i | sub_start_i);
  assign g_a  = exec | (idle & gate_a_s_i);
  assign g_x  = idle & gate_x_s_i;
  assign i_s  = idle & inv_s_i;
  assign g_r  = exec | (idle & gate_r_u_i);
  assign i_u  = exec | (idle & inv_u_i);
  assign cin  = exec ? `NEGATE_CARRY : (idle & carry_in_i);
  assign st_a = exec | (idle & store_a_i);
  assign st_x = idle & store_x_i;

  assign busy_o = ~idle;
  assign done_o = (state_q == SEQ_DONE);

  // ==========================================================
  // Bus gating, one slice per bit
  // ==========================================================
  // S is zero-predominant: with both sources gated each bit is the AND
  // of the two; with none gated the bus rests at zero.
  genvar b;
  generate
    for (b = 0; b < `WORD_W; b++)
    begin : g_bit
      logic a_term;
      logic x_term;
      assign a_term     = g_a ? (acc_q[b] ^ i_s) : 1'b1;
      assign x_term     = g_x ? (idx_q[b] ^ i_s) : 1'b1;
      assign s_bus[b]   = (g_a | g_x) & a_term & x_term;
      assign u_bus[b]   = g_r & (opnd_q[b] ^ i_u);
    end
  endgenerate

  // ==========================================================
  // Adder
  // ==========================================================
  signed_adder_core #(
    .WIDTH   (`WORD_W)
  ) signed_adder_core_inst (
    .s_bus_i (s_bus),
    .u_bus_i (u_bus),
    .carry_i (cin),
    .sum_o   (sum),
    .carry_o (sum_carry),
    .ovf_o   (sum_ovf)
  );

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      opnd_q <= `WORD_RESET;
    end
    else if (ld_r)
    begin
      opnd_q <= mem_data_i;
    end
  end

  // The shift stage is a straight pass here, so the stored word is
  // exactly the adder output.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc_q <= `WORD_RESET;
    end
    else if (st_a)
    begin
      acc_q <= sum;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      idx_q <= `WORD_RESET;
    end
    else if (st_x)
    begin
      idx_q <= sum;
    end
  end

  // Result bus and flags are sampled every cycle so software-visible
  // status always reflects the last sum on the bus.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_q <= `WORD_RESET;
      sign_q   <= 1'b0;
      zero_q   <= 1'b1;
      carry_q  <= 1'b0;
      ovf_q    <= 1'b0;
    end
    else
    begin
      result_q <= sum;
      sign_q   <= sum[`SIGN_BIT];
      zero_q   <= (sum == `WORD_RESET);
      carry_q  <= sum_carry;
      ovf_q    <= sum_ovf;
    end
  end

  assign acc_o    = acc_q;
  assign idx_o    = idx_q;
  assign opnd_o   = opnd_q;
  assign result_o = result_q;
  assign sign_o   = sign_q;
  assign zero_o   = zero_q;
  assign carry_o  = carry_q;
  assign ovf_o    = ovf_q;

  // ==========================================================
  // Checks
  // ==========================================================
  sign_tracks_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ##1 (sign_o == result_o[`SIGN_BIT])
      && (sign_o == (result_o > `MAX_POSITIVE)))
    else $error("sign flag disagrees with result bit 15");

  positive_range_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !sign_o |-> (result_o <= `MAX_POSITIVE))
    else $error("positive result exceeds largest positive value");

  sum_wraps_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> result_o == $past(s_bus) + $past(u_bus) + {15'h0000, $past(cin)})
    else $error("result is not the wrapped three-input sum");

  carry_drop_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> carry_o == ({1'b0, $past(s_bus)} + {1'b0, $past(u_bus)}
                         + {16'h0000, $past(cin)} > 17'h0ffff))
    else $error("carry flag does not match the discarded carry");

  overflow_flag_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    1'b1 |=> ovf_o == (($past(s_bus[15]) == $past(u_bus[15]))
                       && (result_o[15] != $past(s_bus[15]))))
    else $error("overflow flag wrong for the last sum");

  negate_opnd_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (idle && !sub_start_i && store_a_i && gate_r_u_i && inv_u_i
     && carry_in_i && !gate_a_s_i && !gate_x_s_i)
    |=> (acc_o + $past(opnd_o)) == `WORD_RESET)
    else $error("negation plus operand is not zero");

  load_first_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (idle && sub_start_i) |=> exec && (opnd_o == $past(mem_data_i)))
    else $error("operand not loaded before subtract gating");

  sub_gating_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    exec |-> (u_bus == ~opnd_q) && cin && (s_bus == acc_q))
    else $error("subtract gating of buses or carry is wrong");

  sub_result_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (idle && sub_start_i) |=> ##1 done_o
      && (acc_o == $past(acc_o, 1) - $past(opnd_o, 1)))
    else $error("accumulator does not hold the difference");

  store_path_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    st_a |=> (acc_o == result_o))
    else $error("stored accumulator differs from result bus");

  inv_x_gate_a : assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (idle && gate_x_s_i && inv_s_i && !gate_a_s_i && !gate_r_u_i
     && !carry_in_i && !sub_start_i) |=> result_o == ~$past(idx_o))
    else $error("inverted index register not on first bus");

endmodule : signed_adder_datapath
`default_nettype wire

// *** verilog/adder_params.svh ***
// Constants of the signed adder datapath: widths, bit positions,
// reset values and the carry used for negation.
// Assumes inclusion by bare name from the package and design files.
`ifndef ADDER_PARAMS_SVH
`define ADDER_PARAMS_SVH

`define WORD_W        16
`define SIGN_BIT      15
`define MAG_MSB       14
`define MAX_POSITIVE  16'h7fff
`define WORD_RESET    16'h0000
`define NEGATE_CARRY  1'b1

`endif

// *** verilog/adder_pkg.sv ***
// Types shared by the signed adder datapath files.
// Assumes adder_params.svh is on the include path.
`default_nettype none
`include "adder_params.svh"

package adder_pkg;

  typedef logic [`WORD_W-1:0] word_t;

  // Gray codes from SEQ_IDLE through SEQ_EXEC to SEQ_DONE; the return to SEQ_IDLE flips both bits.
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_EXEC = 2'b01,
    SEQ_DONE = 2'b11
  } seq_state_t;

endpackage : adder_pkg
`default_nettype wire

// *** verilog/signed_adder_core.sv ***
// Passive three-input adder: first bus, second bus and carry-in.
// Assumes both buses are already gated and complemented by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "adder_params.svh"

module signed_adder_core #(
  parameter int WIDTH = `WORD_W
) (
  // Adder inputs
  input  wire logic [WIDTH-1:0] s_bus_i,
  input  wire logic [WIDTH-1:0] u_bus_i,
  input  wire logic             carry_i,
  // Adder outputs
  output logic      [WIDTH-1:0] sum_o,
  output logic                  carry_o,
  output logic                  ovf_o
);

  logic [WIDTH:0] full_sum;

  // The carry out of the top bit is kept apart from the word, so the
  // result wraps modulo two to the word width.
  assign full_sum = {1'b0, s_bus_i} + {1'b0, u_bus_i} + {{WIDTH{1'b0}}, carry_i};
  assign sum_o    = full_sum[WIDTH-1:0];
  assign carry_o  = full_sum[WIDTH];

  // Signed overflow: both inputs share a sign that the sum does not.
  assign ovf_o = (s_bus_i[WIDTH-1] == u_bus_i[WIDTH-1])
               && (sum_o[WIDTH-1] != s_bus_i[WIDTH-1]);

endmodule : signed_adder_core
`default_nettype wire

// *** tb/seq_ctrl_model.sv ***
// Control sequencer model: drives the datapath's load, gating and store strobes.
// Assumes strobes are sampled on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_model
  import adder_pkg::*;
(
  // Clock
  input  wire logic             clk_i,
  // Strobes and memory operand
  output logic [9:0]            strobe_o,
  output adder_pkg::word_t      mem_data_o
);
  // ==========================================================
  // Strobe encoding and transfers
  localparam logic [9:0] LD = 10'h100, GA = 10'h080, GR = 10'h010;
  localparam logic [9:0] IU = 10'h008, CI = 10'h004, SA = 10'h002;

  initial
  begin
    strobe_o   = 10'h000;
    mem_data_o = 16'h0000;
  end

  // Released memory data shows its inverse so a stale word is never read by luck.
  task automatic step(input logic [9:0] s, input word_t m);
    @(posedge clk_i);
    #1;
    strobe_o   = s;
    mem_data_o = m;
    @(posedge clk_i);
    #1;
    strobe_o   = 10'h000;
    mem_data_o = ~m;
  endtask : step

  task automatic sub_mem(input word_t m);
    step(LD, m);
    step(GA | GR | IU | CI | SA, 16'h0000);
  endtask : sub_mem
endmodule : seq_ctrl_model
`default_nettype wire

// *** tb/signed_adder_datapath_tb_top.sv ***
// Self-checking testbench of the signed adder datapath.
// Assumes adder_pkg and seq_ctrl_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module signed_adder_datapath_tb_top;
  import adder_pkg::*;
  // ==========================================================
  // Signals and instances
  localparam logic [9:0] SUB = 10'h200, LD = 10'h100, GA = 10'h080, GX = 10'h040;
  localparam logic [9:0] IS = 10'h020, GR = 10'h010, IU = 10'h008, CI = 10'h004;
  localparam logic [9:0] SA = 10'h002, SX = 10'h001;
  localparam int LIMIT = 2000;
  logic       sys_clk;
  logic       resetn;
  logic [9:0] strobe;
  word_t      mem_data, acc, idx, opnd, result;
  logic       busy, done, sign, zero, carry, ovf;
  int         err_count, total_checks, cycles;

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  seq_ctrl_model seq_ctrl_model_inst (.clk_i(sys_clk), .strobe_o(strobe), .mem_data_o(mem_data));

  signed_adder_datapath signed_adder_datapath_inst (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .mem_data_i(mem_data), .load_r_i(strobe[8]),
    .gate_a_s_i(strobe[7]), .gate_x_s_i(strobe[6]), .inv_s_i(strobe[5]),
    .gate_r_u_i(strobe[4]), .inv_u_i(strobe[3]), .carry_in_i(strobe[2]),
    .store_a_i(strobe[1]), .store_x_i(strobe[0]), .sub_start_i(strobe[9]),
    .busy_o(busy), .done_o(done), .acc_o(acc), .idx_o(idx), .opnd_o(opnd),
    .result_o(result), .sign_o(sign), .zero_o(zero), .carry_o(carry), .ovf_o(ovf));

  // ==========================================================
  // Checking and closing
  task automatic check(input word_t seen, input word_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      complete_run();
    end
  end

  // Loads a register through the operand register and the plain second bus.
  task automatic set_reg(input word_t v, input logic [9:0] store);
    seq_ctrl_model_inst.step(LD, v);
    seq_ctrl_model_inst.step(GR | store, 16'h0000);
  endtask : set_reg

  // ==========================================================
  // Scenarios
  task automatic t_sub_op();
    word_t       av[6] = '{16'h000a, 16'h0004, 16'h0006, 16'hfffb, 16'h7fff, 16'h8000};
    word_t       mv[6] = '{16'h0005, 16'h0006, 16'hfffc, 16'hfffb, 16'hffff, 16'h0001};
    word_t       d;
    logic [16:0] full;
    for (int i = 0; i < 6; i++)
    begin
      set_reg(av[i], SA);
      seq_ctrl_model_inst.sub_mem(mv[i]);
      d    = av[i] - mv[i];
      full = {1'b0, av[i]} + {1'b0, ~mv[i]} + 17'h00001;
      check(opnd, mv[i]);
      check(acc, d);
      check(result, d);
      check({15'h0000, sign}, {15'h0000, d[15]});
      check({15'h0000, zero}, {15'h0000, d == 16'h0000});
      check({15'h0000, carry}, {15'h0000, full[16]});
      check({15'h0000, ovf}, {15'h0000, av[i][15] != mv[i][15] && d[15] != av[i][15]});
    end
    $display("t_sub_op done");
  endtask : t_sub_op

  task automatic t_negate();
    word_t nv[4] = '{16'h0005, 16'h7fff, 16'h8000, 16'h0000};
    for (int i = 0; i < 4; i++)
    begin
      seq_ctrl_model_inst.step(LD, nv[i]);
      seq_ctrl_model_inst.step(GR | IU | CI | SA, 16'h0000);
      check(acc, 16'h0000 - nv[i]);
      check({15'h0000, carry}, {15'h0000, nv[i] == 16'h0000});
      seq_ctrl_model_inst.step(GA | GR | SA, 16'h0000);
      check(acc, 16'h0000);
      check({15'h0000, zero}, 16'h0001);
    end
    $display("t_negate done");
  endtask : t_negate

  task automatic t_inv_s();
    set_reg(16'h1234, SX);
    set_reg(16'h0ff0, SA);
    seq_ctrl_model_inst.step(GA | GX | SA, 16'h0000);
    check(acc, 16'h0230);
    // Plain inverted index on the first bus, with no carry and no store.
    seq_ctrl_model_inst.step(GX | IS, 16'h0000);
    check(result, 16'hedcb);
    check(acc, 16'h0230);
    seq_ctrl_model_inst.step(GX | IS | CI | SA, 16'h0000);
    check(acc, 16'hedcc);
    seq_ctrl_model_inst.step(GA | IS | SA, 16'h0000);
    check(acc, 16'h1233);
    check(idx, 16'h1234);
    $display("t_inv_s done");
  endtask : t_inv_s

  task automatic t_seq();
    set_reg(16'h0004, SA);
    seq_ctrl_model_inst.step(SUB, 16'h0006);
    check({14'h0000, busy, done}, 16'h0002);
    check(opnd, 16'h0006);
    @(posedge sys_clk);
    #1;
    check({14'h0000, busy, done}, 16'h0003);
    check(acc, 16'hfffe);
    check(result, 16'hfffe);
    @(posedge sys_clk);
    #1;
    check({14'h0000, busy, done}, 16'h0000);
    $display("t_seq done");
  endtask : t_seq

  initial
  begin
    err_count    = 0;
    total_checks = 0;
    cycles       = 0;
    resetn       = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    check(acc, 16'h0000);
    check({15'h0000, busy}, 16'h0000);
    resetn = 1'b1;
    t_sub_op();
    t_negate();
    t_inv_s();
    t_seq();
    complete_run();
  end
endmodule : signed_adder_datapath_tb_top
`default_nettype wire
